// file: hfsm_far_model.sv
/*
 far-side model: software batch traffic and downstream remote wake.
 assumes the same clock and reset as hfsm_top; stimulus pulses come from the bench.
*/
`timescale 1ns/1ns
module hfsm_far_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic batch_en_in,
    input wire logic batch_abort_in,
    input wire logic start_in,
    input wire logic finish_in,
    input wire logic wake_req_in,
    output logic busy_out,
    output logic wake_out
);
    // a batch is dispatched only while dispatch is enabled
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_out <= 1'b0;
        end else if (batch_abort_in || finish_in) begin
            busy_out <= 1'b0; // abort kills the batch at once
        end else if (start_in && batch_en_in) begin
            busy_out <= 1'b1;
        end
    end
    // wake held as a level, so a slow device is modelled too
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wake_out <= 1'b0;
        end else begin
            wake_out <= wake_req_in;
        end
    end
endmodule // hfsm_far_model

// file: hfsm_pkg.sv
/*
 package of the host functional state machine: command and flag bit positions,
 state codes, timing constants and the command carrier.
 assumes a single 50 MHz internal clock.
*/
package hfsm_pkg;

    // bit positions in host_state_control
    localparam int unsigned BIT_CLOCK_STOP = 7;
    localparam int unsigned BIT_SOFT_RESTART = 5;
    localparam int unsigned BIT_BUS_RESET = 4;
    localparam int unsigned BIT_BUS_IDLE = 3;
    localparam int unsigned BIT_WAKE = 2;
    localparam int unsigned BIT_RUNNING = 1;

    // clock and timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SETTLE_MS = 12;
    localparam int unsigned RESUME_MS = 20;
    localparam int unsigned SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;
    localparam int unsigned RESUME_CYC = (CLK_HZ / 1000) * RESUME_MS;
    localparam int unsigned CNT_W = 21;

    // register values
    localparam logic [7:0] CTRL_READ_RESET = 8'h00;
    localparam logic [7:0] CTRL_READ_BLOCKED = 8'h00;
    localparam logic [3:0] PORTS_ALL = 4'hf;
    localparam logic [3:0] PORTS_NONE = 4'h0;

    // one-hot state codes; each equals its flag in host_state_control
    typedef enum logic [7:0] {
        CLOCK_STOPPED_STATE = 8'h80,
        BUS_RESET_STATE = 8'h10,
        BUS_IDLE_STATE = 8'h08,
        WAKE_SIGNALLING_STATE = 8'h04,
        RUNNING_STATE = 8'h02
    } hfsm_state_t;

    typedef struct packed {
        logic clock_stop_command;
        logic soft_restart_command;
        logic bus_reset_command;
        logic bus_idle_command;
        logic wake_signalling_command;
        logic running_command;
    } hfsm_cmd_t;

endpackage

// file: hfsm_top.sv
/*
 host functional state machine: five-state controller with its control register,
 frame-start and batch gating, downstream SE0 / resume drive and clock stop.
 assumes all inputs synchronous to SYS_CLK_IN; RSTN_IN is the power-on reset,
 EXT_RESET_N_IN the sampled master reset pin.
*/
//
// Contract
// - current state reads as one flag: bits 7, 4, 3, 2, 1.
// - a command is a one written to its bit of the control register.
// - control register is unreadable while clocks are stopped.
// - running state enables frame starts and batch processing.
// - running command moves bus reset to running.
// - running command also moves bus idle straight to running.
// - power-on, pin reset or bus reset command force bus reset.
// - bus reset state drives SE0 on all four ports.
// - soft restart, or idle command in running, enters bus idle.
// - idle command during a batch waits for batch completion.
// - soft restart aborts any running batch at once.
// - bus idle disables dispatch and frame starts, clocks keep running.
// - bus idle keeps watching remote wake and the wake command.
// - remote wake or wake command moves bus idle to wake signalling.
// - wake signalling drives resume 20 ms, then enters running alone.
// - clock stop entered only by its command from bus idle.
// - clock stopped state ignores wake and all commands.
// - only the pin reset or power-on reset (RSTN_IN) leaves clock stopped, into bus reset.
// - after power-on or pin reset the block stays disabled 12 ms.
`timescale 1ns/1ns
module hfsm_top
    import hfsm_pkg::*;
#(
    parameter int unsigned SETTLE_CYC_P = SETTLE_CYC,
    parameter int unsigned RESUME_CYC_P = RESUME_CYC
) (
    input wire logic SYS_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire logic EXT_RESET_N_IN,
    input wire logic CTRL_WR_IN,
    input wire logic [7:0] CTRL_WDATA_IN,
    input wire logic CTRL_RD_IN,
    output logic [7:0] CTRL_RDATA_OUT,
    input wire logic WAKE_IN,
    input wire logic BATCH_BUSY_IN,
    output logic BATCH_EN_OUT,
    output logic BATCH_ABORT_OUT,
    output logic SOF_EN_OUT,
    output logic [3:0] PORT_SE0_OUT,
    output logic [3:0] PORT_RESUME_OUT,
    output logic CLK_STOP_OUT,
    output logic READY_OUT
);

    hfsm_state_t state_r;
    hfsm_state_t state_nxt;
    hfsm_cmd_t cmd;
    logic [CNT_W-1:0] settle_cnt_r;
    logic [CNT_W-1:0] resume_cnt_r;
    logic idle_pend_r;
    logic idle_pend_nxt;
    logic ready;
    logic wr_ok;
    logic soft_ok;
    logic [7:0] rdata_r;
    logic abort_r;

    assign cmd = '{
        clock_stop_command: CTRL_WDATA_IN[BIT_CLOCK_STOP],
        soft_restart_command: CTRL_WDATA_IN[BIT_SOFT_RESTART],
        bus_reset_command: CTRL_WDATA_IN[BIT_BUS_RESET],
        bus_idle_command: CTRL_WDATA_IN[BIT_BUS_IDLE],
        wake_signalling_command: CTRL_WDATA_IN[BIT_WAKE],
        running_command: CTRL_WDATA_IN[BIT_RUNNING]
    };

    assign ready = (settle_cnt_r == '0);
    // writes count only once settled and with clocks running
    assign wr_ok = CTRL_WR_IN && ready && EXT_RESET_N_IN && (state_r != CLOCK_STOPPED_STATE);
    assign soft_ok = wr_ok && !cmd.bus_reset_command && cmd.soft_restart_command;

    // pll settle window, restarted by the pin reset
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            settle_cnt_r <= CNT_W'(SETTLE_CYC_P - 1);
        end else if (CE_IN) begin
            if (!EXT_RESET_N_IN) begin
                settle_cnt_r <= CNT_W'(SETTLE_CYC_P - 1);
            end else if (!ready) begin
                settle_cnt_r <= settle_cnt_r - CNT_W'(1);
            end
        end
    end

    // next state; one write may carry several bits, bus reset wins, then soft restart
    always_comb begin
        state_nxt = state_r;
        idle_pend_nxt = idle_pend_r;
        if (!EXT_RESET_N_IN) begin
            state_nxt = BUS_RESET_STATE;
            idle_pend_nxt = 1'b0;
        end else if (!ready || state_r == CLOCK_STOPPED_STATE) begin
            state_nxt = state_r;
        end else if (wr_ok && cmd.bus_reset_command) begin
            state_nxt = BUS_RESET_STATE;
            idle_pend_nxt = 1'b0;
        end else if (soft_ok) begin
            state_nxt = BUS_IDLE_STATE;
            idle_pend_nxt = 1'b0;
        end else begin
            case (state_r)
                BUS_RESET_STATE: begin
                    if (wr_ok && cmd.running_command) begin
                        state_nxt = RUNNING_STATE;
                    end
                end
                RUNNING_STATE: begin
                    if ((wr_ok && cmd.bus_idle_command) || idle_pend_r) begin
                        if (BATCH_BUSY_IN) begin
                            idle_pend_nxt = 1'b1;
                        end else begin
                            state_nxt = BUS_IDLE_STATE;
                            idle_pend_nxt = 1'b0;
                        end
                    end
                end
                BUS_IDLE_STATE: begin
                    if (wr_ok && cmd.running_command) begin
                        state_nxt = RUNNING_STATE;
                    end else if (wr_ok && cmd.clock_stop_command) begin
                        state_nxt = CLOCK_STOPPED_STATE;
                    end else if ((wr_ok && cmd.wake_signalling_command) || WAKE_IN) begin
                        state_nxt = WAKE_SIGNALLING_STATE;
                    end
                end
                WAKE_SIGNALLING_STATE: begin
                    if (resume_cnt_r == '0) begin
                        state_nxt = RUNNING_STATE;
                    end
                end
                default: begin
                    state_nxt = BUS_RESET_STATE;
                end
            endcase
            // anything else written here falls through unchanged
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_r <= BUS_RESET_STATE;
            idle_pend_r <= 1'b0;
        end else if (CE_IN) begin
            state_r <= state_nxt;
            idle_pend_r <= idle_pend_nxt;
        end
    end

    // resume duration; reloaded while outside wake signalling so each entry starts the full 20 ms
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            resume_cnt_r <= '0;
        end else if (CE_IN) begin
            if (state_r != WAKE_SIGNALLING_STATE) begin
                resume_cnt_r <= CNT_W'(RESUME_CYC_P - 1);
            end else if (resume_cnt_r != '0) begin
                resume_cnt_r <= resume_cnt_r - CNT_W'(1);
            end
        end
    end

    // abort is a one-cycle pulse; the batch engine must drop busy on it
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            abort_r <= 1'b0;
        end else if (CE_IN) begin
            abort_r <= soft_ok && ready && EXT_RESET_N_IN;
        end
    end

    // read data; stopped clocks give nothing back
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rdata_r <= CTRL_READ_RESET;
        end else if (CE_IN && CTRL_RD_IN) begin
            if (state_r == CLOCK_STOPPED_STATE) begin
                rdata_r <= CTRL_READ_BLOCKED;
            end else begin
                rdata_r <= state_r;
            end
        end
    end

    assign CTRL_RDATA_OUT = rdata_r;
    assign BATCH_ABORT_OUT = abort_r;
    assign READY_OUT = ready;
    // gating taken from one-hot state flops; frame start and dispatch also need ready
    assign SOF_EN_OUT = state_r[BIT_RUNNING] && ready;
    assign BATCH_EN_OUT = state_r[BIT_RUNNING] && ready;
    assign PORT_SE0_OUT = state_r[BIT_BUS_RESET] ? PORTS_ALL : PORTS_NONE;
    assign PORT_RESUME_OUT = state_r[BIT_WAKE] ? PORTS_ALL : PORTS_NONE;
    assign CLK_STOP_OUT = state_r[BIT_CLOCK_STOP];

    // checks
    state_flag_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && CTRL_RD_IN && state_r != CLOCK_STOPPED_STATE) |=>
        (CTRL_RDATA_OUT == $past(state_r)))
        else $error("read flag does not match state");

    stopped_read_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && CTRL_RD_IN && state_r == CLOCK_STOPPED_STATE) |=> (CTRL_RDATA_OUT == 8'h00))
        else $error("read returned data while clocks stopped");

    sof_gating_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (SOF_EN_OUT || BATCH_EN_OUT) |-> (state_r == RUNNING_STATE && PORT_RESUME_OUT == 4'h0))
        else $error("frame starts outside running");

    run_cmd_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && wr_ok && CTRL_WDATA_IN == 8'h02 &&
        (state_r == BUS_RESET_STATE || state_r == BUS_IDLE_STATE)) |=> (state_r == RUNNING_STATE))
        else $error("running command not taken");

    pin_reset_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && !EXT_RESET_N_IN) |=> (state_r == BUS_RESET_STATE && !READY_OUT))
        else $error("pin reset did not force bus reset");

    se0_drive_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == BUS_RESET_STATE) |-> (PORT_SE0_OUT == 4'hf && !SOF_EN_OUT))
        else $error("ports not in SE0 during bus reset");

    soft_abort_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && soft_ok) |=> (BATCH_ABORT_OUT && state_r == BUS_IDLE_STATE))
        else $error("soft restart did not abort and idle");

    idle_wait_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && EXT_RESET_N_IN && state_r == RUNNING_STATE && BATCH_BUSY_IN && !wr_ok) |=>
        (state_r == RUNNING_STATE))
        else $error("idle entered during a batch");

    remote_wake_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && EXT_RESET_N_IN && ready && state_r == BUS_IDLE_STATE && WAKE_IN && !CTRL_WR_IN)
        |=> (state_r == WAKE_SIGNALLING_STATE))
        else $error("remote wake missed in bus idle");

    resume_end_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && EXT_RESET_N_IN && state_r == WAKE_SIGNALLING_STATE && resume_cnt_r == '0 &&
        !soft_ok && !(wr_ok && cmd.bus_reset_command)) |=> (state_r == RUNNING_STATE))
        else $error("resume did not end in running");

    stop_entry_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        $rose(state_r == CLOCK_STOPPED_STATE) |-> ($past(state_r) == BUS_IDLE_STATE))
        else $error("clock stop entered from wrong state");

    stop_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == CLOCK_STOPPED_STATE && EXT_RESET_N_IN) |=> (state_r == CLOCK_STOPPED_STATE))
        else $error("left clock stop without pin reset");

    settle_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (!READY_OUT) |=> (state_r == BUS_RESET_STATE && !BATCH_ABORT_OUT))
        else $error("activity during pll settle");

    illegal_cmd_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && EXT_RESET_N_IN && state_r == BUS_RESET_STATE && CTRL_WR_IN &&
        CTRL_WDATA_IN == 8'h84) |=> (state_r == BUS_RESET_STATE))
        else $error("illegal command changed state");

    se0_only_reset_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r != BUS_RESET_STATE) |-> (PORT_SE0_OUT == 4'h0))
        else $error("SE0 driven outside bus reset");

    resume_drive_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == WAKE_SIGNALLING_STATE) |-> (PORT_RESUME_OUT == 4'hf && !SOF_EN_OUT && !BATCH_EN_OUT))
        else $error("resume drive or gating wrong");

    idle_gate_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == BUS_IDLE_STATE) |-> (!SOF_EN_OUT && !BATCH_EN_OUT && !CLK_STOP_OUT))
        else $error("bus idle gating wrong");

    run_enable_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == RUNNING_STATE && READY_OUT) |-> (SOF_EN_OUT && BATCH_EN_OUT))
        else $error("running without frame starts");

    bus_reset_cmd_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && wr_ok && cmd.bus_reset_command) |=> (state_r == BUS_RESET_STATE))
        else $error("bus reset command not taken");

    idle_cmd_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && wr_ok && CTRL_WDATA_IN == 8'h08 && state_r == RUNNING_STATE && !BATCH_BUSY_IN)
        |=> (state_r == BUS_IDLE_STATE))
        else $error("idle command not taken");

    idle_release_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && EXT_RESET_N_IN && state_r == RUNNING_STATE && idle_pend_r && !BATCH_BUSY_IN &&
        !CTRL_WR_IN) |=> (state_r == BUS_IDLE_STATE))
        else $error("pending idle not taken after batch");

    wake_cmd_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && wr_ok && CTRL_WDATA_IN == 8'h04 && state_r == BUS_IDLE_STATE)
        |=> (state_r == WAKE_SIGNALLING_STATE))
        else $error("wake command not taken");

    stop_cmd_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && wr_ok && CTRL_WDATA_IN == 8'h80 && state_r == BUS_IDLE_STATE)
        |=> (state_r == CLOCK_STOPPED_STATE && CLK_STOP_OUT))
        else $error("clock stop command not taken");

    stop_exit_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && state_r == CLOCK_STOPPED_STATE && !EXT_RESET_N_IN) |=> (state_r == BUS_RESET_STATE))
        else $error("pin reset did not leave clock stop");

    stop_wake_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == CLOCK_STOPPED_STATE && EXT_RESET_N_IN && WAKE_IN) |=> (CLK_STOP_OUT))
        else $error("remote wake left clock stop");

    run_ignore_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && EXT_RESET_N_IN && state_r == RUNNING_STATE && CTRL_WR_IN && !idle_pend_r &&
        CTRL_WDATA_IN == 8'h84) |=> (state_r == RUNNING_STATE))
        else $error("illegal command left running");

    settle_load_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (CE_IN && !EXT_RESET_N_IN) |=> (settle_cnt_r == CNT_W'(SETTLE_CYC_P - 1)))
        else $error("settle window not restarted");

    ce_freeze_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (!CE_IN) |=> ($stable(state_r) && $stable(settle_cnt_r)))
        else $error("state moved while clock enable low");

    soft_restart_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (BATCH_BUSY_IN && soft_ok) ##1 (BATCH_ABORT_OUT));

    run_from_reset_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == BUS_RESET_STATE) ##1 (state_r == RUNNING_STATE));

    idle_after_batch_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (idle_pend_r && BATCH_BUSY_IN) ##[1:20] (state_r == BUS_IDLE_STATE));

    wake_to_run_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == WAKE_SIGNALLING_STATE) ##1 (state_r == RUNNING_STATE));

    stop_exit_c: cover property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
        (state_r == CLOCK_STOPPED_STATE) ##1 (state_r == BUS_RESET_STATE));

endmodule // hfsm_top

// file: hfsm_top_tb.sv
/*
 self-checking bench for hfsm_top with the far-side model.
 assumes short settle and resume counts; inputs change on the falling edge.
*/
`timescale 1ns/1ns
module hfsm_top_tb;
    import hfsm_pkg::*;
    localparam int unsigned SETTLE_T = 8;
    localparam int unsigned RESUME_T = 6;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ext_n = 1'b1;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic start = 1'b0;
    logic finish = 1'b0;
    logic wake_req = 1'b0;
    logic [7:0] rdata;
    logic batch_en, abort, sof_en, clk_stop, ready, wake, busy;
    logic [3:0] se0, resume;
    int errors = 0;
    int checks = 0;
    int n = 0;
    int abort_cnt = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (abort === 1'b1) abort_cnt++;

    hfsm_top #(.SETTLE_CYC_P(SETTLE_T), .RESUME_CYC_P(RESUME_T)) hfsm_top_inst (
        .SYS_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .EXT_RESET_N_IN(ext_n),
        .CTRL_WR_IN(wr), .CTRL_WDATA_IN(wdata), .CTRL_RD_IN(rd), .CTRL_RDATA_OUT(rdata),
        .WAKE_IN(wake), .BATCH_BUSY_IN(busy), .BATCH_EN_OUT(batch_en),
        .BATCH_ABORT_OUT(abort), .SOF_EN_OUT(sof_en), .PORT_SE0_OUT(se0),
        .PORT_RESUME_OUT(resume), .CLK_STOP_OUT(clk_stop), .READY_OUT(ready));
    hfsm_far_model hfsm_far_model_inst (
        .clk_in(clk), .rstn_in(rstn), .batch_en_in(batch_en), .batch_abort_in(abort),
        .start_in(start), .finish_in(finish), .wake_req_in(wake_req),
        .busy_out(busy), .wake_out(wake));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // trailing idle cycle keeps the strobe from being reassigned in one step
    task automatic wr_cmd(input logic [7:0] d);
        wr = 1'b1;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] exp);
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk("state flags", exp, rdata);
        @(negedge clk);
    endtask
    function automatic logic probe(input int which);
        case (which)
            0: return ready;
            1: return resume[0];
            default: return sof_en;
        endcase
    endfunction
    task automatic wait_hi(input int which, input int lim);
        n = 0;
        while (probe(which) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            chk("wait bound", 8'h01, 8'h00);
            report_and_stop();
        end
    endtask
    task automatic pulse_batch(input logic fin);
        if (fin) finish = 1'b1;
        else start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        finish = 1'b0;
        @(negedge clk);
    endtask

    initial begin
        cyc(4);
        rstn = 1'b1;
        chk("ready low", 8'h00, {7'h00, ready});
        wr_cmd(8'h02);
        wait_hi(0, 20);
        chk("settle length", 8'h01, {7'h00, n >= SETTLE_T - 6 && n <= SETTLE_T});
        rd_chk(8'h10);
        chk("se0 ports", 8'h0f, {4'h0, se0});
        chk("frame gate", 8'h00, {7'h00, sof_en});
        cyc(4);
        $display("test reset done");
        wr_cmd(8'h02);
        rd_chk(8'h02);
        chk("frame gate", 8'h01, {7'h00, sof_en});
        chk("dispatch", 8'h01, {7'h00, batch_en});
        chk("se0 ports", 8'h00, {4'h0, se0});
        wr_cmd(8'h04);
        wr_cmd(8'h80);
        rd_chk(8'h02);
        ce = 1'b0;
        wr_cmd(8'h08); // frozen, so the idle command is lost
        ce = 1'b1;
        rd_chk(8'h02);
        $display("test running done");
        pulse_batch(1'b0);
        wr_cmd(8'h08);
        cyc(3);
        rd_chk(8'h02);
        pulse_batch(1'b1);
        cyc(1);
        rd_chk(8'h08);
        chk("frame gate", 8'h00, {7'h00, sof_en});
        chk("dispatch", 8'h00, {7'h00, batch_en});
        chk("clock stop", 8'h00, {7'h00, clk_stop});
        $display("test idle after batch done");
        wr_cmd(8'h02);
        rd_chk(8'h02);
        pulse_batch(1'b0);
        wr_cmd(8'h20);
        chk("abort pulses", 8'h01, abort_cnt[7:0]);
        chk("batch busy", 8'h00, {7'h00, busy});
        rd_chk(8'h08);
        wr_cmd(8'h02); // quick return before devices sleep
        rd_chk(8'h02);
        $display("test soft restart done");
        wr_cmd(8'h08);
        rd_chk(8'h08);
        wake_req = 1'b1;
        wait_hi(1, 10);
        wake_req = 1'b0;
        chk("resume ports", 8'h0f, {4'h0, resume});
        chk("frame gate", 8'h00, {7'h00, sof_en});
        wait_hi(2, 20);
        chk("resume length", 8'h01, {7'h00, n >= RESUME_T - 3 && n <= RESUME_T + 1});
        rd_chk(8'h02);
        wr_cmd(8'h08);
        wr_cmd(8'h04);
        rd_chk(8'h04);
        wait_hi(2, 20);
        $display("test wake done");
        wr_cmd(8'h10);
        rd_chk(8'h10);
        chk("se0 ports", 8'h0f, {4'h0, se0});
        cyc(4);
        wr_cmd(8'h02);
        wr_cmd(8'h08);
        cyc(4);
        wr_cmd(8'h80);
        chk("clock stop", 8'h01, {7'h00, clk_stop});
        rd_chk(8'h00);
        wr_cmd(8'h10);
        wake_req = 1'b1;
        cyc(3);
        wake_req = 1'b0;
        chk("clock stop", 8'h01, {7'h00, clk_stop});
        chk("se0 ports", 8'h00, {4'h0, se0});
        ext_n = 1'b0;
        cyc(2);
        ext_n = 1'b1;
        chk("ready low", 8'h00, {7'h00, ready});
        chk("se0 ports", 8'h0f, {4'h0, se0});
        wait_hi(0, 20);
        rd_chk(8'h10);
        $display("test clock stop done");
        wr_cmd(8'h02);
        rstn = 1'b0;
        cyc(2);
        chk("se0 ports", 8'h0f, {4'h0, se0});
        rstn = 1'b1;
        wait_hi(0, 20);
        rd_chk(8'h10);
        $display("test power-on reset done");
        report_and_stop();
    end
endmodule // hfsm_top_tb
